/* fcs_pkg.sv */
// Package with constants, encodings and state types for the command string executor.
package fcs_pkg;
    localparam int          ADDR_W        = 16;
    localparam int          MAX_STR       = 9;
    localparam logic [3:0]  BC_EXEC       = 4'h0;
    localparam logic [3:0]  BC_LOAD       = 4'h1;
    localparam logic [3:0]  OP_RDALL      = 4'h0;
    localparam logic [3:0]  OP_WRITE      = 4'h1;
    localparam logic [3:0]  OP_READ       = 4'h2;
    localparam logic [3:0]  OP_FORMAT     = 4'h3;
    localparam logic [3:0]  OP_VERIFY     = 4'h4;
    localparam logic [3:0]  OP_DELMARK    = 4'h5;
    localparam logic [3:0]  OP_LOG_FIRST  = 4'h7;
    localparam logic [3:0]  OP_LOG_LAST   = 4'hB;
    localparam logic [3:0]  OP_LOG_OFFSET = 4'h6;
    localparam logic [7:0]  MAX_TRACK     = 8'h4C;
    localparam logic [7:0]  MIN_SECTOR    = 8'h01;
    localparam logic [7:0]  MAX_SECTOR    = 8'h1A;
    localparam logic [7:0]  ST_OK         = 8'h01;
    localparam logic [7:0]  ST_STRING     = 8'hC0;
    localparam logic [7:0]  ST_OPER       = 8'hA0;
    localparam logic [7:0]  ST_HARD       = 8'h90;
    localparam logic [3:0]  E_STATUS      = 4'h1;
    localparam logic [3:0]  E_NODRV       = 4'h2;
    localparam logic [3:0]  E_MULTI       = 4'h3;
    localparam logic [3:0]  E_OP          = 4'h4;
    localparam logic [3:0]  E_TRACK       = 4'h5;
    localparam logic [3:0]  E_SECTOR      = 4'h6;
    localparam logic [3:0]  E_BUFFER      = 4'h7;
    localparam logic [3:0]  E_LTRACK      = 4'h8;
    localparam logic [3:0]  E_NOTRDY      = 4'h1;
    localparam logic [3:0]  E_HWPROT      = 4'h2;
    localparam logic [3:0]  E_SWPROT      = 4'h3;
    localparam logic [3:0]  E_INOP        = 4'h1;
    localparam logic [3:0]  E_SEEK        = 4'h2;
    localparam logic [3:0]  E_NOTFOUND    = 4'h3;
    localparam logic [3:0]  E_IDCRC       = 4'h4;
    localparam logic [3:0]  E_IDFMT       = 4'h5;
    localparam logic [3:0]  E_DATACRC     = 4'h6;
    localparam logic [3:0]  E_DELETED     = 4'h7;
    localparam logic [3:0]  RETRY_LIMIT   = 4'hA;
    localparam logic [1:0]  REV_LIMIT     = 2'h2;
    localparam logic [7:0]  RDALL_BYTES   = 8'h80;
    localparam logic [7:0]  SECTOR_BYTES  = 8'h80;
    localparam int          MS_NS         = 1000000;
    localparam int          CLK_NS        = 100;
    localparam int          MS_CYC        = MS_NS / CLK_NS;
    localparam logic [ADDR_W-1:0] PTR_RESET = 16'h0000;
    localparam int          FIFO_W        = 8;
    localparam int          FIFO_D        = 4;
    typedef enum logic [4:0] {
        S_IDLE, S_PTR_LO, S_PTR_HI, S_FETCH_REQ, S_FETCH_WAIT, S_CHECK,
        S_SEEK, S_SEEK_WAIT, S_DELAY, S_DISK_REQ, S_DISK_WAIT, S_XFER,
        S_STATUS_REQ, S_STATUS_WAIT, S_DONE
    } fcs_state_t;
endpackage : fcs_pkg

/* fcs_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module fcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              do_wr = in_valid && in_ready;
    wire              do_rd = out_valid && out_ready;

    // Full and empty come straight from the fill count.
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    // Pointers and count.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (do_rd) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    // Storage, written without reset.
    always_ff @(posedge mclk) begin
        if (do_wr) mem[wr_ptr] <= in_data;
    end
endmodule : fcs_fifo
`default_nettype wire

/* fcs_executor.sv */
// Command string executor: byte port, pointers, string fetch, checks, disk sequencing, status.
`timescale 1ns/10ps
`default_nettype none
module fcs_executor (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Host byte command port.
    input  wire logic        cmd_strobe,
    input  wire logic [7:0]  cmd_byte,
    // DMA master port into host memory.
    output logic             dma_req,
    output logic             dma_we,
    output logic [15:0]      dma_addr,
    output logic [7:0]       dma_wdata,
    input  wire logic        dma_ack,
    input  wire logic [7:0]  dma_rdata,
    // Drive status inputs.
    input  wire logic [3:0]  drv_ready,
    input  wire logic [3:0]  drv_hw_protect,
    input  wire logic [3:0]  drv_sw_protect,
    input  wire logic        index_pulse,
    // Disk channel control.
    output logic             seek_start,
    output logic [7:0]       seek_track,
    input  wire logic        seek_done,
    input  wire logic        seek_ok,
    output logic             disk_start,
    output logic [3:0]       disk_op,
    output logic [3:0]       disk_drive,
    output logic [7:0]       disk_sector,
    output logic [15:0]      disk_id_track,
    input  wire logic        disk_done,
    input  wire logic [3:0]  disk_fault,
    // Disk data stream into the controller.
    input  wire logic        rd_valid,
    output logic             rd_ready,
    input  wire logic [7:0]  rd_data,
    // Disk data stream out of the controller.
    output logic             wr_valid,
    input  wire logic        wr_ready,
    output logic [7:0]       wr_data,
    // Status of the executor.
    output logic             busy
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    fcs_pkg::fcs_state_t   state;
    logic [15:0]           ptr [16];
    logic [3:0]            ptr_sel;
    logic [7:0]            ptr_lo;
    logic [7:0]            str [fcs_pkg::MAX_STR];
    logic [3:0]            idx;
    logic [3:0]            fetch_len;
    logic [15:0]           base;
    logic [7:0]            status;
    logic [3:0]            retries;
    logic [1:0]            revs;
    logic [7:0]            xcount;
    logic [16:0]           ms_cnt;
    logic [7:0]            ms_left;
    logic [7:0]            fifo_out;
    logic                  fifo_ovalid;
    logic                  fifo_iready;

    // ****************************************************************
    // Decoding of the fetched string
    // ****************************************************************
    wire [3:0]  opc      = str[0][7:4];
    wire [3:0]  drv      = str[0][3:0];
    wire        is_log   = (opc >= fcs_pkg::OP_LOG_FIRST) && (opc <= fcs_pkg::OP_LOG_LAST);
    wire [3:0]  base_op  = is_log ? opc - fcs_pkg::OP_LOG_OFFSET : opc;
    wire        uses_buf = (base_op == fcs_pkg::OP_RDALL) || (base_op == fcs_pkg::OP_WRITE)
                           || (base_op == fcs_pkg::OP_READ);
    wire        uses_sec = (base_op != fcs_pkg::OP_RDALL) && (base_op != fcs_pkg::OP_FORMAT);
    wire [3:0]  base_len = uses_buf ? 4'd7 : (uses_sec ? 4'd5 : 4'd4);
    wire [3:0]  lt_idx   = base_len;
    wire [15:0] log_trk  = {str[lt_idx], str[lt_idx+4'd1]};
    wire [15:0] buf_addr = {str[6], str[5]};
    wire        one_hot  = (drv != 4'h0) && ((drv & (drv - 4'h1)) == 4'h0);
    wire        is_write = (base_op == fcs_pkg::OP_WRITE) || (base_op == fcs_pkg::OP_FORMAT)
                           || (base_op == fcs_pkg::OP_DELMARK);
    wire        valid_op = (opc <= fcs_pkg::OP_DELMARK) || is_log;
    wire [7:0]  chk;

    // Opcode tells the fetcher how many bytes the string holds.
    wire [3:0]  hdr_op   = str[0][7:4];
    wire        hdr_log  = (hdr_op >= fcs_pkg::OP_LOG_FIRST) && (hdr_op <= fcs_pkg::OP_LOG_LAST);
    wire [3:0]  need_len = (idx == 4'd0) ? 4'd4 : (base_len + (hdr_log ? 4'd2 : 4'd0));

    // String and drive checks in the documented priority, first failure wins.
    assign chk =
        (str[1] != 8'h00)                                   ? (fcs_pkg::ST_STRING | {4'h0, fcs_pkg::E_STATUS}) :
        (drv == 4'h0)                                       ? (fcs_pkg::ST_STRING | {4'h0, fcs_pkg::E_NODRV})  :
        !one_hot                                            ? (fcs_pkg::ST_STRING | {4'h0, fcs_pkg::E_MULTI})  :
        !valid_op                                           ? (fcs_pkg::ST_STRING | {4'h0, fcs_pkg::E_OP})     :
        (str[2] != 8'h00 || str[3] > fcs_pkg::MAX_TRACK)    ? (fcs_pkg::ST_STRING | {4'h0, fcs_pkg::E_TRACK})  :
        (uses_sec && (str[4] < fcs_pkg::MIN_SECTOR || str[4] > fcs_pkg::MAX_SECTOR))
                                                            ? (fcs_pkg::ST_STRING | {4'h0, fcs_pkg::E_SECTOR}) :
        (uses_buf && buf_addr[15])                          ? (fcs_pkg::ST_STRING | {4'h0, fcs_pkg::E_BUFFER}) :
        (is_log && (log_trk[15:8] != 8'h00 || log_trk[7:0] > fcs_pkg::MAX_TRACK))
                                                            ? (fcs_pkg::ST_STRING | {4'h0, fcs_pkg::E_LTRACK}) :
        ((drv_ready & drv) == 4'h0)                         ? (fcs_pkg::ST_OPER | {4'h0, fcs_pkg::E_NOTRDY})   :
        (is_write && (drv_hw_protect & drv) != 4'h0)        ? (fcs_pkg::ST_OPER | {4'h0, fcs_pkg::E_HWPROT})   :
        (is_write && (drv_sw_protect & drv) != 4'h0)        ? (fcs_pkg::ST_OPER | {4'h0, fcs_pkg::E_SWPROT})   :
        8'h00;

    wire        ms_tick  = (ms_cnt == 17'(fcs_pkg::MS_CYC - 1));
    wire        xfer_len_done = (xcount == (base_op == fcs_pkg::OP_RDALL ? fcs_pkg::RDALL_BYTES
                                                                          : fcs_pkg::SECTOR_BYTES));
    wire        reads_host = (base_op == fcs_pkg::OP_WRITE);
    wire        writes_host = (base_op == fcs_pkg::OP_RDALL) || (base_op == fcs_pkg::OP_READ);
    wire        retry_crc = (disk_fault == fcs_pkg::E_DATACRC) && (retries < fcs_pkg::RETRY_LIMIT - 4'd1);
    wire        retry_nf  = (disk_fault == fcs_pkg::E_NOTFOUND) && (revs < fcs_pkg::REV_LIMIT - 2'd1);
    // A disk byte is stored only on a completed handshake, so a byte held by the channel is never taken twice.
    wire        rd_take   = rd_valid && rd_ready;

    // ****************************************************************
    // Disk read buffer between the channel and host DMA writes
    // ****************************************************************
    fcs_fifo #(.WIDTH(fcs_pkg::FIFO_W), .DEPTH(fcs_pkg::FIFO_D)) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (rd_take),
        .in_ready  (fifo_iready),
        .in_data   (rd_data),
        .out_valid (fifo_ovalid),
        .out_ready (state == fcs_pkg::S_XFER && writes_host && dma_req && dma_ack),
        .out_data  (fifo_out)
    );

    // Readiness to the disk channel, registered.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) rd_ready <= 1'b0;
        else         rd_ready <= fifo_iready && !(rd_valid && rd_ready);
    end

    // ****************************************************************
    // Main sequencer
    // ****************************************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= fcs_pkg::S_IDLE;
            for (int i = 0; i < 16; i++) ptr[i] <= fcs_pkg::PTR_RESET;
            for (int i = 0; i < fcs_pkg::MAX_STR; i++) str[i] <= 8'h00;
            ptr_sel <= 4'h0; ptr_lo <= 8'h00; idx <= 4'h0; fetch_len <= 4'h0;
            base <= 16'h0000; status <= 8'h00; retries <= 4'h0; revs <= 2'h0;
            xcount <= 8'h00; ms_cnt <= 17'h0; ms_left <= 8'h00;
            dma_req <= 1'b0; dma_we <= 1'b0; dma_addr <= 16'h0000; dma_wdata <= 8'h00;
            seek_start <= 1'b0; seek_track <= 8'h00; disk_start <= 1'b0; disk_op <= 4'h0;
            disk_drive <= 4'h0; disk_sector <= 8'h00; disk_id_track <= 16'h0000;
            wr_valid <= 1'b0; wr_data <= 8'h00; busy <= 1'b0;
        end else begin
            seek_start <= 1'b0;
            disk_start <= 1'b0;
            case (state)
                fcs_pkg::S_IDLE: begin
                    busy <= 1'b0;
                    if (cmd_strobe) begin
                        ptr_sel <= cmd_byte[3:0];
                        if (cmd_byte[7:4] == fcs_pkg::BC_LOAD) state <= fcs_pkg::S_PTR_LO;
                        else if (cmd_byte[7:4] == fcs_pkg::BC_EXEC) begin
                            base  <= ptr[cmd_byte[3:0]];
                            idx   <= 4'h0;
                            busy  <= 1'b1;
                            state <= fcs_pkg::S_FETCH_REQ;
                        end
                    end
                end
                fcs_pkg::S_PTR_LO: if (cmd_strobe) begin
                    ptr_lo <= cmd_byte;
                    state  <= fcs_pkg::S_PTR_HI;
                end
                fcs_pkg::S_PTR_HI: if (cmd_strobe) begin
                    ptr[ptr_sel] <= {cmd_byte, ptr_lo};
                    state        <= fcs_pkg::S_IDLE;
                end
                fcs_pkg::S_FETCH_REQ: begin
                    dma_req   <= 1'b1;
                    dma_we    <= 1'b0;
                    dma_addr  <= base + 16'(idx);
                    fetch_len <= need_len;
                    state     <= fcs_pkg::S_FETCH_WAIT;
                end
                fcs_pkg::S_FETCH_WAIT: if (dma_ack) begin
                    dma_req  <= 1'b0;
                    str[idx] <= dma_rdata;
                    idx      <= idx + 4'h1;
                    if (idx + 4'h1 >= fetch_len && idx != 4'h0) state <= fcs_pkg::S_CHECK;
                    else state <= fcs_pkg::S_FETCH_REQ;
                end
                fcs_pkg::S_CHECK: begin
                    if (idx < need_len && valid_op) state <= fcs_pkg::S_FETCH_REQ;
                    else if (chk != 8'h00) begin
                        status <= chk;
                        state  <= fcs_pkg::S_STATUS_REQ;
                    end else begin
                        retries    <= 4'h0;
                        revs       <= 2'h0;
                        seek_track <= str[3];
                        seek_start <= 1'b1;
                        state      <= fcs_pkg::S_SEEK_WAIT;
                    end
                end
                fcs_pkg::S_SEEK_WAIT: if (seek_done) begin
                    if (seek_ok) begin
                        retries <= 4'h0;
                        ms_left <= str[4];
                        ms_cnt  <= 17'h0;
                        state   <= (base_op == fcs_pkg::OP_RDALL) ? fcs_pkg::S_DELAY : fcs_pkg::S_DISK_REQ;
                    end else if (retries < fcs_pkg::RETRY_LIMIT - 4'd1) begin
                        retries    <= retries + 4'h1;
                        seek_start <= 1'b1;
                    end else begin
                        status <= fcs_pkg::ST_HARD | {4'h0, fcs_pkg::E_SEEK};
                        state  <= fcs_pkg::S_STATUS_REQ;
                    end
                end
                fcs_pkg::S_DELAY: begin
                    if (index_pulse && ms_cnt == 17'h0 && ms_left == str[4]) ms_cnt <= 17'h1;
                    else if (ms_cnt != 17'h0 || ms_left != str[4]) ms_cnt <= ms_tick ? 17'h0 : ms_cnt + 17'h1;
                    if (ms_left == 8'h00 && (index_pulse || ms_cnt != 17'h0 || str[4] != 8'h00))
                        state <= fcs_pkg::S_DISK_REQ;
                    else if (ms_tick) ms_left <= ms_left - 8'h01;
                end
                fcs_pkg::S_DISK_REQ: begin
                    disk_start    <= 1'b1;
                    disk_op       <= base_op;
                    disk_drive    <= drv;
                    disk_sector   <= str[4];
                    disk_id_track <= is_log ? log_trk : {str[2], str[3]};
                    xcount        <= 8'h00;
                    dma_addr      <= buf_addr;
                    state         <= reads_host ? fcs_pkg::S_XFER : fcs_pkg::S_DISK_WAIT;
                end
                fcs_pkg::S_XFER: begin
                    if (reads_host) begin
                        if (wr_valid && wr_ready) begin
                            wr_valid <= 1'b0;
                            xcount   <= xcount + 8'h01;
                            dma_addr <= dma_addr + 16'h0001;
                        end else if (!wr_valid && !dma_req && !xfer_len_done) dma_req <= 1'b1;
                        else if (dma_req && dma_ack) begin
                            dma_req  <= 1'b0;
                            wr_data  <= dma_rdata;
                            wr_valid <= 1'b1;
                        end
                        if (xfer_len_done) state <= fcs_pkg::S_DISK_WAIT;
                    end else begin
                        if (dma_req && dma_ack) begin
                            dma_req  <= 1'b0;
                            xcount   <= xcount + 8'h01;
                            dma_addr <= dma_addr + 16'h0001;
                        end else if (!dma_req && fifo_ovalid && !xfer_len_done) begin
                            dma_req   <= 1'b1;
                            dma_we    <= 1'b1;
                            dma_wdata <= fifo_out;
                        end
                        if (xfer_len_done && !dma_req) begin
                            dma_we <= 1'b0;
                            status <= fcs_pkg::ST_OK;
                            state  <= fcs_pkg::S_STATUS_REQ;
                        end
                    end
                end
                fcs_pkg::S_DISK_WAIT: if (disk_done) begin
                    if (disk_fault == 4'h0) begin
                        status <= fcs_pkg::ST_OK;
                        state  <= writes_host ? fcs_pkg::S_XFER : fcs_pkg::S_STATUS_REQ;
                        xcount <= 8'h00;
                    end else if (retry_crc) begin
                        retries <= retries + 4'h1;
                        state   <= fcs_pkg::S_DISK_REQ;
                    end else if (retry_nf) begin
                        revs  <= revs + 2'h1;
                        state <= fcs_pkg::S_DISK_REQ;
                    end else begin
                        status <= fcs_pkg::ST_HARD | {4'h0, disk_fault};
                        state  <= fcs_pkg::S_STATUS_REQ;
                    end
                end
                fcs_pkg::S_STATUS_REQ: begin
                    dma_req   <= 1'b1;
                    dma_we    <= 1'b1;
                    dma_addr  <= base + 16'h0001;
                    dma_wdata <= status;
                    state     <= fcs_pkg::S_STATUS_WAIT;
                end
                fcs_pkg::S_STATUS_WAIT: if (dma_ack) begin
                    dma_req <= 1'b0;
                    dma_we  <= 1'b0;
                    state   <= fcs_pkg::S_DONE;
                end
                fcs_pkg::S_DONE: begin
                    busy  <= 1'b0;
                    state <= fcs_pkg::S_IDLE;
                end
                default: state <= fcs_pkg::S_IDLE;
            endcase
        end
    end
endmodule : fcs_executor
`default_nettype wire

/* fcs_exec_monitor.sv */
// Checker watching the ports of the command string executor.
`timescale 1ns/10ps
`default_nettype none
module fcs_exec_monitor (
    input wire logic        mclk, sys_rst, cmd_strobe, dma_req, dma_we, dma_ack, seek_start, disk_start, busy,
    input wire logic [15:0] dma_addr,
    input wire logic [7:0]  dma_wdata, seek_track, disk_sector,
    input wire logic [3:0]  disk_op, disk_drive
);
    logic [8:0] last;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Remembers direction and data of the last finished access, so the status write can be judged.
    always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst) last <= '0; else if (dma_ack && dma_req) last <= {dma_we, dma_wdata};
    a_req_held: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr)) else $error("req dropped");
    a_ack_ends_req: assert property (dma_ack && dma_req |=> !dma_req) else $error("req kept");
    a_idle_quiet: assert property (!busy |-> !dma_req && !seek_start && !disk_start) else $error("idle work");
    a_exec_fetch: assert property ($rose(busy) |-> $past(cmd_strobe) ##[0:4] (dma_req && !dma_we))
        else $error("no fetch");
    a_status_last: assert property ($fell(busy) |-> last[8] && (last[7:0] == 8'h01 || last[7]))
        else $error("bad status");
    a_track_range: assert property (seek_start |-> seek_track <= 8'h4C) else $error("bad track");
    a_one_drive: assert property (disk_start |-> $onehot(disk_drive) && disk_op <= 4'h5) else $error("bad drive");
    a_sector_range: assert property (disk_start && disk_op inside {4'h1, 4'h2, 4'h4, 4'h5}
        |-> disk_sector inside {[8'h01:8'h1A]}) else $error("bad sector");
endmodule : fcs_exec_monitor
`default_nettype wire

/* fcs_host_mem.sv */
// Host memory model answering the executor's DMA accesses.
`timescale 1ns/10ps
`default_nettype none
module fcs_host_mem (
    input wire logic        mclk, dma_req, dma_we,
    input wire logic [15:0] dma_addr,
    input wire logic [7:0]  dma_wdata,
    input wire logic [1:0]  ack_wait,
    output logic            dma_ack,
    output logic [7:0]      dma_rdata
);
    logic [7:0] mem [65536];
    int         cnt = 0;
    initial {dma_ack, dma_rdata} = '0;
    // Acknowledges after ack_wait idle cycles; read data toggles so it means nothing outside an acknowledge.
    always @(posedge mclk) begin
        dma_ack <= 1'b0;
        dma_rdata <= ~dma_rdata;
        if (dma_req && !dma_ack && cnt < ack_wait) cnt <= cnt + 1;
        else if (dma_req && !dma_ack) begin
            cnt <= 0;
            dma_ack <= 1'b1;
            if (dma_we) mem[dma_addr] <= dma_wdata;
            else dma_rdata <= mem[dma_addr];
        end
    end
endmodule : fcs_host_mem
`default_nettype wire

/* test_floppy_command_string_executor.sv */
// Testbench running command strings through the executor and checking status bytes.
`timescale 1ns/10ps
`default_nettype none
module test_floppy_command_string_executor;
    logic mclk = 0, sys_rst = 1, cmd_strobe = 0, seek_ok = 1, seek_done = 0, disk_done = 0;
    logic busy, dma_req, dma_we, dma_ack, seek_start, disk_start, rd_ready;
    logic [7:0] cmd_byte = 8'h00, rd_cnt = 8'h00, dma_wdata, dma_rdata, seek_track, disk_sector, exp;
    logic [15:0] dma_addr, disk_id_track, last_id, base;
    logic [3:0] drv_ready = 4'hF, drv_hw_protect = 4'h0, drv_sw_protect = 4'h0, disk_fault = 4'h0;
    logic [3:0] disk_op, disk_drive, last_op, flt, misc, tries, op;
    logic [63:0] s;
    int errors = 0, tests_run = 0, seeks, starts;
    // Row: string bytes 1-8, status, fault, {seek fail, not ready, hw, sw}, tries (F: any).
    logic [83:0] rows [24] = '{84'h3100004C_00000000_01_0_0_1, 84'h4100001A_1A000000_01_0_0_1,
        84'h52000002_01000000_01_0_0_1, 84'h91000005_00070000_01_0_0_1, 84'h31070000_00000000_C1_0_0_0,
        84'h30000000_00000000_C2_0_0_0, 84'h35000000_00000000_C3_0_0_0, 84'h61000000_00000000_C4_0_0_0,
        84'h3100004D_00000000_C5_0_0_0, 84'h31000100_00000000_C5_0_0_0, 84'h41000000_00000000_C6_0_0_0,
        84'h41000000_1B000000_C6_0_0_0, 84'h21000000_01008000_C7_0_0_0, 84'h31000000_00000000_A1_0_4_0,
        84'h51000000_01000000_A2_0_2_0, 84'h51000000_01000000_A3_0_1_0, 84'h41000000_01000000_94_4_0_F,
        84'h41000000_01000000_95_5_0_F, 84'h41000000_01000000_97_7_0_F, 84'h41000000_01000000_96_6_0_A,
        84'h41000000_01000000_93_3_0_2, 84'h41000000_01000000_92_0_8_A, 84'h41000000_01000000_91_1_0_F,
        84'h21000000_01002000_01_0_0_1};
    initial forever #50 mclk = ~mclk;
    fcs_host_mem u_mem (.mclk, .dma_req, .dma_we, .dma_addr, .dma_wdata, .ack_wait(base[5:4]), .dma_ack, .dma_rdata);
    fcs_executor u_dut (.mclk, .sys_rst, .cmd_strobe, .cmd_byte, .dma_req, .dma_we, .dma_addr, .dma_wdata, .dma_ack,
        .dma_rdata, .drv_ready, .drv_hw_protect, .drv_sw_protect, .index_pulse(1'b0), .seek_start, .seek_track,
        .seek_done, .seek_ok, .disk_start, .disk_op, .disk_drive, .disk_sector, .disk_id_track, .disk_done,
        .disk_fault, .rd_valid(1'b1), .rd_ready, .rd_data(rd_cnt), .wr_valid(), .wr_ready(1'b1), .wr_data(), .busy);
    // Disk channel answers every seek and operation one cycle later, records what was asked and streams a count.
    always @(posedge mclk) begin
        seeks += int'(seek_start);
        starts += int'(disk_start);
        if (rd_ready === 1'b1) rd_cnt <= rd_cnt + 8'h01;
        if (disk_start) {last_op, last_id} = {disk_op, disk_id_track};
        {seek_done, disk_done} <= #1 {seek_start, disk_start};
    end
    task automatic check(input logic [15:0] got, want, input string what);
        tests_run++;
        if (got !== want) begin
            errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask : check
    task automatic put(input logic [7:0] b);
        @(posedge mclk) #1 cmd_strobe = 1;
        cmd_byte = b;
        @(posedge mclk) #1 cmd_strobe = 0;
    endtask : put
    task automatic exec_wait(input logic [3:0] p);
        int n = 0;
        put({4'h0, p});
        check(16'(busy), 16'h1, "busy");
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge mclk) #1 n++;
        end
        if (n == 5000) check(16'h0, 16'h1, "timeout");
    endtask : exec_wait
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // Cuts a hang short long after all strings should have finished.
    initial begin
        #5000000 errors++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge mclk);
        #1 sys_rst = 0;
        for (int i = 0; i < 24; i++) begin
            {s, exp, flt, misc, tries} = rows[i];
            base = 16'h1000 + 16'(i * 16);
            op = s[63:60];
            for (int k = 0; k < 8; k++) u_mem.mem[base + 16'(k)] = s[63 - 8 * k -: 8];
            {drv_ready, drv_hw_protect, drv_sw_protect} = {{4{~misc[2]}}, {4{misc[1]}}, {4{misc[0]}}};
            seek_ok = ~misc[3];
            disk_fault = flt;
            {seeks, starts} = '0;
            put({4'h1, base[3:0] ^ 4'(i)}); put(base[7:0]); put(base[15:8]);
            exec_wait(4'(i));
            check(16'(u_mem.mem[base + 16'h1]), 16'(exp), "status");
            if (tries != 4'hF) check(16'(misc[3] ? seeks : starts), 16'(tries), "tries");
            if (exp == 8'h01) check(last_id, op >= 4'h7 ? s[31:16] : s[47:32], "id track");
            if (exp == 8'h01) check(16'(last_op), 16'(op >= 4'h7 ? op - 4'h6 : op), "op");
            if (op == 4'h2 && exp == 8'h01)
                for (int j = 0; j < 128; j++) check(16'(u_mem.mem[16'h2000 + 16'(j)]), 16'(j), "data");
            $display("test %0d done", i);
        end
        exec_wait(4'h0);
        check(16'(u_mem.mem[16'h1101]), 16'h00C1, "stale status");
        end_sim();
    end
endmodule : test_floppy_command_string_executor
bind fcs_executor fcs_exec_monitor u_mon (.mclk, .sys_rst, .cmd_strobe, .dma_req, .dma_we, .dma_ack, .seek_start,
    .disk_start, .busy, .dma_addr, .dma_wdata, .seek_track, .disk_sector, .disk_op, .disk_drive);
`default_nettype wire
